// *** rtl/mcr_top.sv ***
/*
 * Monitor configuration register bank: overtemperature, conversion rate and
 * channel skip registers, the overtemperature pin driver and error gating.
 * Assumes the serial interface decodes accesses into single-cycle strobes on
 * the register port, and that the comparator logic supplies the overtemp state.
 */
`default_nettype none
module mcr_top #(
	parameter int VOLT_CYC = mcr_pkg::VOLT_CONV_CYC,
	parameter int T9_CYC = mcr_pkg::TEMP9_CONV_CYC,
	parameter int T12_CYC = mcr_pkg::TEMP12_CONV_CYC,
	parameter int RR_CYC = mcr_pkg::ROUND_CYC,
	parameter int FAN_TMO_CYC = mcr_pkg::FAN_TIMEOUT_CYC
) (
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	// Register port
	input wire logic [7:0] reg_addr_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_wdata_in,
	output logic [7:0] reg_rdata_out,
	// Pin function select from the fan divisor register, bit 7 then bit 6
	input wire logic [1:0] pin_fn_in,
	// Overtemperature state and shared pin
	input wire logic ovt_active_in,
	output logic ovt_one_shot_out,
	input wire logic ovt_pin_in,
	output logic ovt_pin_out,
	output logic ovt_pin_oe_n_out,
	// Temperature fraction from the converter
	input wire logic temp_upd_in,
	input wire logic [3:0] temp_frac_in,
	// Limit checks
	input wire logic [7:0] limit_err_in,
	output logic [7:0] err_event_out,
	output logic [7:0] value_zero_out,
	// Fans
	input wire logic [mcr_pkg::NUM_FAN-1:0] fan_en_in,
	input wire logic [mcr_pkg::NUM_FAN-1:0] fan_tach_in,
	// Conversion control
	output logic conv_start_out,
	output logic conv_done_out,
	output logic [3:0] conv_chan_out,
	output logic res12_out
);
	logic [7:1] ovt_cfg_r, ovt_cfg_nxt;
	logic ovt_stat_r, ovt_stat_nxt;
	logic rate_r, rate_nxt;
	logic [7:0] skip_r, skip_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	logic [7:0] err_r, err_nxt;
	logic pin_ovt;
	logic drive_low;

	mcr_seq_if sif();

	assign pin_ovt = (pin_fn_in == mcr_pkg::PIN_FN_OVT);

	always_comb begin
		ovt_cfg_nxt = ovt_cfg_r;
		ovt_stat_nxt = ovt_stat_r;
		rate_nxt = rate_r;
		skip_nxt = skip_r;
		if (pin_ovt) begin
			ovt_stat_nxt = ovt_pin_in;
		end
		if (temp_upd_in) begin
			if (skip_r[mcr_pkg::TEMP_SKIP_BIT]) begin
				ovt_cfg_nxt[7:4] = 4'h0;
			end else if (ovt_cfg_r[mcr_pkg::OVT_RES_BIT]) begin
				ovt_cfg_nxt[7:4] = temp_frac_in;
			end else begin
				// Bits 4 to 6 carry no meaning here; zero keeps reads repeatable.
				ovt_cfg_nxt[7:4] = {temp_frac_in[3], 3'h0};
			end
		end
		if (reg_wr_in) begin
			case (reg_addr_in)
				mcr_pkg::ADDR_OVT_CFG: begin
					ovt_cfg_nxt = reg_wdata_in[7:1];
				end
				mcr_pkg::ADDR_RATE: begin
					rate_nxt = reg_wdata_in[mcr_pkg::RATE_SEL_BIT];
				end
				mcr_pkg::ADDR_SKIP: begin
					skip_nxt = reg_wdata_in;
				end
				default: begin
				end
			endcase
		end
	end

	always_comb begin
		rdata_nxt = rdata_r;
		if (reg_rd_in) begin
			case (reg_addr_in)
				mcr_pkg::ADDR_OVT_CFG: rdata_nxt = {ovt_cfg_r, ovt_stat_r};
				mcr_pkg::ADDR_RATE: rdata_nxt = {7'h00, rate_r};
				mcr_pkg::ADDR_SKIP: rdata_nxt = skip_r;
				default: rdata_nxt = 8'h00;
			endcase
		end
		err_nxt = limit_err_in & ~skip_r;
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ovt_cfg_r <= mcr_pkg::OVT_CFG_RST[7:1];
			ovt_stat_r <= mcr_pkg::OVT_CFG_RST[mcr_pkg::OVT_STAT_BIT];
			rate_r <= mcr_pkg::RATE_RST[mcr_pkg::RATE_SEL_BIT];
			skip_r <= mcr_pkg::SKIP_RST;
			rdata_r <= 8'h00;
			err_r <= 8'h00;
		end else if (ce_in) begin
			ovt_cfg_r <= ovt_cfg_nxt;
			ovt_stat_r <= ovt_stat_nxt;
			rate_r <= rate_nxt;
			skip_r <= skip_nxt;
			rdata_r <= rdata_nxt;
			err_r <= err_nxt;
		end
	end

	// Open drain: the pin is only ever pulled low, so the level is a pull-up's job.
	assign drive_low = pin_ovt
		&& (ovt_active_in ^ ovt_cfg_r[mcr_pkg::OVT_POL_BIT]);
	assign ovt_pin_out = 1'b0;
	assign ovt_pin_oe_n_out = !drive_low;
	assign ovt_one_shot_out = ovt_cfg_r[mcr_pkg::OVT_MODE_BIT];
	assign res12_out = ovt_cfg_r[mcr_pkg::OVT_RES_BIT];
	assign reg_rdata_out = rdata_r;
	assign err_event_out = err_r;
	assign value_zero_out = skip_r;

	assign sif.skip = skip_r;
	assign sif.cont = rate_r;
	assign sif.res12 = ovt_cfg_r[mcr_pkg::OVT_RES_BIT];
	assign conv_start_out = sif.conv_start;
	assign conv_done_out = sif.conv_done;
	assign conv_chan_out = sif.chan;

	mcr_seq #(
		.VOLT_CYC(VOLT_CYC),
		.T9_CYC(T9_CYC),
		.T12_CYC(T12_CYC),
		.RR_CYC(RR_CYC),
		.FAN_TMO_CYC(FAN_TMO_CYC)
	) u_seq (
		.ref_clk_in(ref_clk_in),
		.rst_n_in(rst_n_in),
		.ce_in(ce_in),
		.fan_en_in(fan_en_in),
		.fan_tach_in(fan_tach_in),
		.sif(sif)
	);

	a_ovt_status_mirror: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		ce_in && pin_ovt && !(reg_wr_in && reg_addr_in == mcr_pkg::ADDR_OVT_CFG)
		|=> ovt_stat_r == $past(ovt_pin_in))
		else $error("status bit does not mirror pin");
	a_pin_drive_pol: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		!ovt_pin_oe_n_out |-> pin_ovt && ovt_pin_out == 1'b0
		&& ovt_active_in != ovt_cfg_r[mcr_pkg::OVT_POL_BIT])
		else $error("pin driven against polarity");
	a_pin_off: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		pin_fn_in == mcr_pkg::PIN_FN_OFF |-> ovt_pin_oe_n_out)
		else $error("pin driven while off");
	a_rate_rsvd_zero: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		ce_in && reg_rd_in && reg_addr_in == mcr_pkg::ADDR_RATE
		|=> reg_rdata_out[7:1] == 7'h00 && reg_rdata_out[0] == $past(rate_r))
		else $error("rate register read wrong");
	a_skip_no_err: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		ce_in && $past(ce_in) |-> (err_event_out & $past(skip_r)) == 8'h00)
		else $error("error from disabled channel");
	a_frac_capture: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		ce_in && temp_upd_in && !reg_wr_in && res12_out && !skip_r[mcr_pkg::TEMP_SKIP_BIT]
		|=> ovt_cfg_r[7:4] == $past(temp_frac_in))
		else $error("fraction nibble not captured");
endmodule
`default_nettype wire

// *** rtl/mcr_pkg.sv ***
/*
 * Constants for the monitor configuration register bank: offsets, bit positions,
 * reset values, sequencer timing and the sequencer state type.
 * Assumes a 40 MHz clock; times are held in microseconds and turned into cycles here.
 */
`default_nettype none
package mcr_pkg;
	localparam logic [7:0] ADDR_OVT_CFG = 8'h06;
	localparam logic [7:0] ADDR_RATE = 8'h07;
	localparam logic [7:0] ADDR_SKIP = 8'h08;
	localparam logic [7:0] OVT_CFG_RST = 8'h01;
	localparam logic [7:0] RATE_RST = 8'h00;
	localparam logic [7:0] SKIP_RST = 8'h00;
	localparam int OVT_STAT_BIT = 0;
	localparam int OVT_POL_BIT = 1;
	localparam int OVT_MODE_BIT = 2;
	localparam int OVT_RES_BIT = 3;
	localparam int OVT_FRAC_LO = 4;
	localparam int RATE_SEL_BIT = 0;
	localparam int TEMP_SKIP_BIT = 7;
	localparam int NUM_VOLT = 7;
	localparam int NUM_FAN = 2;
	localparam logic [1:0] PIN_FN_OFF = 2'h0;
	localparam logic [1:0] PIN_FN_OVT = 2'h1;
	localparam int FAN_PULSES = 2;
	localparam int CLK_MHZ = 40;
	localparam int VOLT_CONV_US = 3000;
	localparam int TEMP9_CONV_US = 3600;
	localparam int TEMP12_CONV_US = 23500;
	localparam int ROUND_US = 728000;
	localparam int FAN_TIMEOUT_US = 1000000;
	localparam int VOLT_CONV_CYC = VOLT_CONV_US * CLK_MHZ;
	localparam int TEMP9_CONV_CYC = TEMP9_CONV_US * CLK_MHZ;
	localparam int TEMP12_CONV_CYC = TEMP12_CONV_US * CLK_MHZ;
	localparam int ROUND_CYC = ROUND_US * CLK_MHZ;
	localparam int FAN_TIMEOUT_CYC = FAN_TIMEOUT_US * CLK_MHZ;
	localparam logic [3:0] CHAN_TEMP = 4'h7;
	localparam logic [3:0] CHAN_FAN0 = 4'h8;
	localparam logic [3:0] CHAN_END = 4'hA;
	typedef enum logic [1:0] {
		SEQ_WAIT = 2'b00,
		SEQ_NEXT = 2'b01,
		SEQ_CONV = 2'b10,
		SEQ_FAN = 2'b11
	} mcr_seq_state_t;
endpackage
`default_nettype wire

// *** rtl/mcr_seq_if.sv ***
/*
 * Carries configuration to the sequencer and its conversion events back.
 * Assumes both ends share the register bank clock.
 */
`default_nettype none
interface mcr_seq_if;
	logic [7:0] skip;
	logic cont;
	logic res12;
	logic conv_start;
	logic conv_done;
	logic [3:0] chan;
	modport bank (output skip, output cont, output res12,
		input conv_start, input conv_done, input chan);
	modport seq (input skip, input cont, input res12,
		output conv_start, output conv_done, output chan);
endinterface
`default_nettype wire

// *** rtl/mcr_seq.sv ***
/*
 * Conversion sequencer: walks voltage, temperature and fan channels, skipping
 * disabled ones, holding voltage and temperature for their conversion time and each fan until two tach pulses or the timeout.
 * Assumes fan inputs are synchronous to the clock and the counts fit 32 bits.
 */
`default_nettype none
module mcr_seq #(
	parameter int VOLT_CYC = mcr_pkg::VOLT_CONV_CYC,
	parameter int T9_CYC = mcr_pkg::TEMP9_CONV_CYC,
	parameter int T12_CYC = mcr_pkg::TEMP12_CONV_CYC,
	parameter int RR_CYC = mcr_pkg::ROUND_CYC,
	parameter int FAN_TMO_CYC = mcr_pkg::FAN_TIMEOUT_CYC
) (
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	// Fans
	input wire logic [mcr_pkg::NUM_FAN-1:0] fan_en_in,
	input wire logic [mcr_pkg::NUM_FAN-1:0] fan_tach_in,
	// Bank side
	mcr_seq_if.seq sif
);
	mcr_pkg::mcr_seq_state_t state_r, state_nxt;
	logic [3:0] chan_r, chan_nxt;
	logic [31:0] cnt_r, cnt_nxt;
	logic [1:0] pulse_r, pulse_nxt;
	logic [mcr_pkg::NUM_FAN-1:0] tach_prev_r;
	logic start_r, start_nxt;
	logic done_r, done_nxt;
	logic fan_idx;
	logic tach_rise;

	assign fan_idx = chan_r[0];
	assign tach_rise = fan_tach_in[fan_idx] & ~tach_prev_r[fan_idx];

	always_comb begin
		state_nxt = state_r;
		chan_nxt = chan_r;
		cnt_nxt = cnt_r;
		pulse_nxt = pulse_r;
		start_nxt = 1'b0;
		done_nxt = 1'b0;
		case (state_r)
			mcr_pkg::SEQ_WAIT: begin
				if (cnt_r <= 32'd1) begin
					state_nxt = mcr_pkg::SEQ_NEXT;
				end else begin
					cnt_nxt = cnt_r - 32'd1;
				end
			end
			mcr_pkg::SEQ_NEXT: begin
				if (chan_r == mcr_pkg::CHAN_END) begin
					chan_nxt = 4'h0;
					if (sif.cont) begin
						state_nxt = mcr_pkg::SEQ_NEXT;
					end else begin
						state_nxt = mcr_pkg::SEQ_WAIT;
						cnt_nxt = 32'(RR_CYC);
					end
				end else if (chan_r < mcr_pkg::CHAN_FAN0) begin
					if (sif.skip[chan_r[2:0]]) begin
						chan_nxt = chan_r + 4'h1;
					end else begin
						start_nxt = 1'b1;
						state_nxt = mcr_pkg::SEQ_CONV;
						if (chan_r != mcr_pkg::CHAN_TEMP) begin
							cnt_nxt = 32'(VOLT_CYC);
						end else if (sif.res12) begin
							cnt_nxt = 32'(T12_CYC);
						end else begin
							cnt_nxt = 32'(T9_CYC);
						end
					end
				end else if (fan_en_in[fan_idx]) begin
					state_nxt = mcr_pkg::SEQ_FAN;
					pulse_nxt = 2'h0;
					cnt_nxt = 32'(FAN_TMO_CYC);
				end else begin
					chan_nxt = chan_r + 4'h1;
				end
			end
			mcr_pkg::SEQ_CONV: begin
				if (cnt_r <= 32'd1) begin
					done_nxt = 1'b1;
					chan_nxt = chan_r + 4'h1;
					state_nxt = mcr_pkg::SEQ_NEXT;
				end else begin
					cnt_nxt = cnt_r - 32'd1;
				end
			end
			mcr_pkg::SEQ_FAN: begin
				// A stopped fan would stall the round, so a timeout bounds the wait.
				if (tach_rise) begin
					pulse_nxt = pulse_r + 2'h1;
				end
				if ((tach_rise && pulse_r == 2'(mcr_pkg::FAN_PULSES - 1)) || cnt_r <= 32'd1) begin
					chan_nxt = chan_r + 4'h1;
					state_nxt = mcr_pkg::SEQ_NEXT;
				end else begin
					cnt_nxt = cnt_r - 32'd1;
				end
			end
			default: begin
				state_nxt = mcr_pkg::SEQ_NEXT;
				chan_nxt = 4'h0;
			end
		endcase
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_r <= mcr_pkg::SEQ_NEXT;
			chan_r <= 4'h0;
			cnt_r <= 32'd0;
			pulse_r <= 2'h0;
			tach_prev_r <= '0;
			start_r <= 1'b0;
			done_r <= 1'b0;
		end else if (ce_in) begin
			state_r <= state_nxt;
			chan_r <= chan_nxt;
			cnt_r <= cnt_nxt;
			pulse_r <= pulse_nxt;
			tach_prev_r <= fan_tach_in;
			start_r <= start_nxt;
			done_r <= done_nxt;
		end
	end

	assign sif.conv_start = start_r;
	assign sif.conv_done = done_r;
	assign sif.chan = chan_r;

	a_skip_no_start: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		ce_in && state_r == mcr_pkg::SEQ_NEXT && chan_r < mcr_pkg::CHAN_FAN0
		&& sif.skip[chan_r[2:0]] |=> !start_r)
		else $error("disabled channel was started");
	a_volt_conv_len: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		start_r && chan_r < mcr_pkg::CHAN_TEMP |-> cnt_r == 32'(VOLT_CYC))
		else $error("voltage conversion time wrong");
	a_temp_conv_len: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		start_r && chan_r == mcr_pkg::CHAN_TEMP
		|-> cnt_r == ($past(sif.res12) ? 32'(T12_CYC) : 32'(T9_CYC)))
		else $error("temperature conversion time wrong");
	a_fan_two_pulses: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		ce_in && state_r == mcr_pkg::SEQ_FAN && tach_rise && pulse_r == 2'h0 && cnt_r > 32'd1
		|=> state_r == mcr_pkg::SEQ_FAN)
		else $error("fan left after one pulse");
	a_round_wait: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		ce_in && state_r == mcr_pkg::SEQ_NEXT && chan_r == mcr_pkg::CHAN_END
		|=> (state_r == mcr_pkg::SEQ_WAIT) == !$past(sif.cont))
		else $error("rate select not honoured");
endmodule
`default_nettype wire

// *** testbench/mcr_pin_model.sv ***
/*
 * Model of the shared overtemperature pin as the board sees it: an open-drain
 * net with a pull-up, resolved from the block's enable and data.
 * Assumes no other party on the board pulls the pin low.
 */
`default_nettype none
module mcr_pin_model (
	// Block side
	input wire logic oe_n_in,
	input wire logic drv_in,
	// Resolved wire level
	output logic pin_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// A released pin floats up through the pull-up, never to the last driven value.
	assign pin_out = oe_n_in ? 1'b1 : drv_in;
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
/*
 * Self-checking bench for the monitor configuration register bank.
 * Assumes the register port takes one-cycle strobes and that the shortened
 * conversion parameters below stand in for the real millisecond counts.
 */
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int VC = 8;
	localparam int T9 = 10;
	localparam int T12 = 20;
	localparam int RR = 30;
	logic clk = 0, rst_n = 0, ce = 1, wr = 0, rd = 0, ovt_act = 0, upd = 0, pin;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, lerr = 8'h00, err_ev, vzero, skip_q = 8'h00;
	logic [1:0] pin_fn = 2'h0, fan_en = 2'h1, tach = 2'h0;
	logic [3:0] frac = 4'h0, chan, cur = 4'hF;
	logic one_shot, pin_o, oe_n, cstart, cdone, res12, cont_q = 0, ign = 1;
	logic gap_ok, res_q = 0, ce_q = 1;
	int bad_count = 0, checks = 0, t0 = 0, texp = 0, endcnt = 0, fancnt = 0;
	mcr_top #(.VOLT_CYC(VC), .T9_CYC(T9), .T12_CYC(T12), .RR_CYC(RR), .FAN_TMO_CYC(40)) u_dut (
		.ref_clk_in(clk), .rst_n_in(rst_n), .ce_in(ce), .reg_addr_in(addr), .reg_wr_in(wr),
		.reg_rd_in(rd), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .pin_fn_in(pin_fn),
		.ovt_active_in(ovt_act), .ovt_one_shot_out(one_shot), .ovt_pin_in(pin),
		.ovt_pin_out(pin_o), .ovt_pin_oe_n_out(oe_n), .temp_upd_in(upd), .temp_frac_in(frac),
		.limit_err_in(lerr), .err_event_out(err_ev), .value_zero_out(vzero),
		.fan_en_in(fan_en), .fan_tach_in(tach), .conv_start_out(cstart),
		.conv_done_out(cdone), .conv_chan_out(chan), .res12_out(res12));
	mcr_pin_model u_pin (.oe_n_in(oe_n), .drv_in(pin_o), .pin_out(pin));
	initial begin
		forever #12.5 clk = ~clk;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] m,
		input string msg);
		checks++;
		if ((got & m) !== (exp & m)) begin
			bad_count++;
			$display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#1 addr = a;
		wdata = d;
		wr = 1;
		@(posedge clk);
		#1 wr = 0;
	endtask
	task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m);
		@(posedge clk);
		#1 addr = a;
		rd = 1;
		@(posedge clk);
		#1 rd = 0;
		chk(rdata, exp, m, "register read");
	endtask
	task automatic frac_upd(input logic [3:0] f);
		@(posedge clk);
		#1 frac = f;
		upd = 1;
		@(posedge clk);
		#1 upd = 0;
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic test_done();
		$display("Counts: %0d checks, %0d mismatches", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// Fan 0 gets a rising tach edge every six cycles so the fan stage ends on pulses.
	always begin
		repeat (3) @(posedge clk);
		#1 tach[0] = ~tach[0];
	end
	// Sequencer monitor, sampling after each edge has settled.
	// An edge with the enable low moved nothing, so it is not counted either.
	// The channel number drops to zero as the round ends, so the gap runs to the next start.
	always begin
		@(posedge clk);
		#2;
		if (rst_n && ce_q) begin
			if (cstart) begin
				cur = chan;
				t0 = 0;
				texp = (chan < 7) ? VC : (res_q ? T12 : T9);
				if (chan < 8) begin
					chk({7'h0, skip_q[chan[2:0]]}, 8'h00, 8'hFF, "skipped start");
				end
			end else begin
				t0++;
			end
			if (cdone && cur < 8) chk(t0[7:0], texp[7:0], 8'hFF, "conversion time");
			if (chan == 4'hA) begin
				endcnt = 1;
			end else if (endcnt > 0 && !cstart) begin
				endcnt++;
			end else if (endcnt > 0) begin
				gap_ok = cont_q ? endcnt < 4 : endcnt >= RR && endcnt < RR + 4;
				if (!ign) begin
					chk({7'h0, gap_ok}, 8'h01, 8'hFF, "round gap");
				end
				ign = 0;
				endcnt = 0;
			end
			// Tach rises every six cycles, so two pulses keep channel 8 for 8 to 13 samples.
			if (chan == 4'h8) begin
				fancnt++;
			end else if (fancnt > 0) begin
				if (!ign) begin
					chk({7'h0, fancnt >= 8 && fancnt <= 13}, 8'h01, 8'hFF, "fan stage");
				end
				fancnt = 0;
			end
			skip_q = vzero;
		end
		res_q = res12;
		ce_q = ce;
	end
	initial begin
		#200us;
		bad_count++;
		$display("BAD %0t watchdog expired", $time);
		test_done();
	end
	initial begin
		idle(2);
		rst_n = 1;
		rd_reg(8'h06, 8'h01, 8'hFF);
		rd_reg(8'h07, 8'h00, 8'hFF);
		rd_reg(8'h08, 8'h00, 8'hFF);
		rd_reg(8'h09, 8'h00, 8'hFF);
		idle(300);
		$display("test reset values done");
		wr_reg(8'h07, 8'hFF);
		cont_q = 1;
		ign = 1;
		rd_reg(8'h07, 8'h01, 8'hFF);
		idle(400);
		$display("test continuous rate done");
		wr_reg(8'h06, 8'h0E);
		rd_reg(8'h06, 8'h0F, 8'h0F);
		chk({6'h0, one_shot, res12}, 8'h03, 8'hFF, "mode outputs");
		idle(200);
		$display("test config bits done");
		pin_fn = 2'h1;
		ovt_act = 1;
		wr_reg(8'h06, 8'h00);
		chk({7'h0, oe_n}, 8'h00, 8'hFF, "active-low drive");
		chk({7'h0, pin}, 8'h00, 8'hFF, "pin level low");
		rd_reg(8'h06, 8'h00, 8'h01);
		wr_reg(8'h06, 8'h02);
		chk({7'h0, oe_n}, 8'h01, 8'hFF, "active-high release");
		rd_reg(8'h06, 8'h01, 8'h01);
		ovt_act = 0;
		idle(1);
		chk({7'h0, oe_n}, 8'h00, 8'hFF, "active-high idle drive");
		pin_fn = 2'h0;
		idle(1);
		chk({7'h0, oe_n}, 8'h01, 8'hFF, "pin off");
		$display("test overtemp pin done");
		wr_reg(8'h06, 8'h08);
		frac_upd(4'hA);
		rd_reg(8'h06, 8'hA0, 8'hF0);
		wr_reg(8'h06, 8'h00);
		frac_upd(4'h9);
		rd_reg(8'h06, 8'h80, 8'h80);
		frac_upd(4'h6);
		rd_reg(8'h06, 8'h00, 8'h80);
		$display("test fraction done");
		wr_reg(8'h08, 8'h81);
		rd_reg(8'h08, 8'h81, 8'hFF);
		chk(vzero, 8'h81, 8'hFF, "value zero mask");
		frac_upd(4'hF);
		rd_reg(8'h06, 8'h00, 8'hF0);
		lerr = 8'hFF;
		idle(2);
		chk(err_ev, 8'h7E, 8'hFF, "suppressed errors");
		idle(400);
		wr_reg(8'h08, 8'h00);
		idle(2);
		chk(err_ev, 8'hFF, 8'hFF, "errors back");
		ce = 0;
		ign = 1;
		wr_reg(8'h08, 8'hFF);
		ce = 1;
		rd_reg(8'h08, 8'h00, 8'hFF);
		$display("test channel skip done");
		wr_reg(8'h07, 8'h00);
		cont_q = 0;
		ign = 1;
		idle(800);
		$display("test round robin done");
		test_done();
	end
endmodule
`default_nettype wire
